// ---- hdl/lpmc_pkg.sv ----
// Package: constants and types shared by both ends of the low-power controller
package lpmc_pkg;
    // ==========================================================
    // Mode select encodings
    localparam logic [1:0] LPMC_SEL_IDLE  = 2'h0;
    localparam logic [1:0] LPMC_SEL_STOP  = 2'h1;
    // ==========================================================
    // Widths and counts
    localparam int LPMC_WUP_W   = 12;
    localparam int LPMC_EXT_N   = 6;
    localparam int LPMC_PER_N   = 24;
    // Gated module clock enables, one bit per block
    localparam int LPMC_GATE_N  = 14;
    localparam int G_DMA        = 0;
    localparam int G_PORT       = 1;
    localparam int G_ADC        = 2;
    localparam int G_UART       = 3;
    localparam int G_I2C        = 4;
    localparam int G_SPI        = 5;
    localparam int G_USB        = 6;
    localparam int G_TMRB       = 7;
    localparam int G_TMRA       = 8;
    localparam int G_TMRD       = 9;
    localparam int G_WDOG       = 10;
    localparam int G_CG         = 11;
    localparam int G_EOSC       = 12;
    localparam int G_RAM        = 13;
    localparam logic [13:0] LPMC_GATE_ALL = 14'h3fff;
    // Source select values
    localparam logic LPMC_CLK_IOSC = 1'b0;
    localparam logic LPMC_CLK_EOSC = 1'b1;
    // Reset-side warm-up default
    localparam logic [11:0] LPMC_WUP_RST = 12'h0ff;
    // ==========================================================
    // Controller states
    typedef enum logic [3:0] {
        LPMC_NORMAL = 4'b0001,
        LPMC_IDLE   = 4'b0010,
        LPMC_STOP   = 4'b0100,
        LPMC_WARM   = 4'b1000
    } lpmc_state_t;
endpackage

// ---- hdl/lpmc_if.sv ----
// Interface: link between low-power controller and core/wake side
`timescale 1ns/1ps
interface lpmc_if;
    import lpmc_pkg::*;
    logic                  wfi;          // Core executes wait-for-interrupt
    logic [1:0]            mode_sel;     // Low-power mode select
    logic [11:0]           warmup;       // Warm-up count
    logic                  ext_clk_sel;  // Software wants external osc
    logic [LPMC_EXT_N-1:0] ext_irq_pins; // Pin wake sources
    logic [LPMC_EXT_N-1:0] ext_irq_en;   // Interface detection enables
    logic [LPMC_PER_N-1:0] periph_irq;   // Peripheral interrupts
    logic [LPMC_PER_N-1:0] periph_en;    // Core-side enables
    logic                  i2c_wake_irq;
    logic                  i2c_wake_en;
    logic                  system_tick_irq;
    logic                  system_tick_en;
    logic                  watchdog_nmi;
    logic                  undervolt_nmi;
    logic                  core_run;     // Core clock enable
    logic                  wake_req;     // Interrupt/NMI wake to core
    logic                  wake_nmi;     // Wake cause was an NMI
    logic [LPMC_GATE_N-1:0] gate_en;     // Module clock enables
    logic                  i2c_wake_run;
    logic                  usb_wake_run;
    logic                  undervolt_run;
    logic                  wdog_clear_ok;
    logic                  clk_src;      // 0 internal, 1 external
    logic                  osc_int_on;
    logic                  sys_clk_ok;
    modport ctrl (
        input  wfi, mode_sel, warmup, ext_clk_sel, ext_irq_pins, ext_irq_en,
        input  periph_irq, periph_en, i2c_wake_irq, i2c_wake_en,
        input  system_tick_irq, system_tick_en, watchdog_nmi, undervolt_nmi,
        output core_run, wake_req, wake_nmi, gate_en, i2c_wake_run,
        output usb_wake_run, undervolt_run, wdog_clear_ok, clk_src,
        output osc_int_on, sys_clk_ok
    );
    modport core (
        output wfi, mode_sel, warmup, ext_clk_sel, ext_irq_pins, ext_irq_en,
        output periph_irq, periph_en, i2c_wake_irq, i2c_wake_en,
        output system_tick_irq, system_tick_en, watchdog_nmi, undervolt_nmi,
        input  core_run, wake_req, wake_nmi, gate_en, i2c_wake_run,
        input  usb_wake_run, undervolt_run, wdog_clear_ok, clk_src,
        input  osc_int_on, sys_clk_ok
    );
endinterface

// ---- hdl/lpmc_ctrl.sv ----
// Low-power mode controller: mode state, clock gating, wake filtering
`timescale 1ns/1ps
module lpmc_ctrl #(
    parameter int WUP_W = lpmc_pkg::LPMC_WUP_W
) (
    input  wire logic ref_clk,
    input  wire logic nrst,
    lpmc_if.ctrl      lnk
);
    import lpmc_pkg::*;

    // ==========================================================
    // Input synchronisers for asynchronous wake sources
    logic [LPMC_EXT_N-1:0] pin_s1_q;
    logic [LPMC_EXT_N-1:0] pin_s2_q;
    logic                  uv_s1_q;
    logic                  uv_s2_q;
    lpmc_state_t           state_q;
    logic [WUP_W-1:0]      wcnt_q;
    logic                  wake_q;
    logic                  nmi_q;
    logic [LPMC_GATE_N-1:0] gate_q;
    logic                  core_q;
    logic                  clk_src_q;
    logic                  osc_q;
    logic                  clk_ok_q;
    logic                  i2c_q;
    logic                  usb_q;
    logic                  wdog_ok_q;
    logic                  ext_arm_q;
    logic                  idle_wake;
    logic                  stop_wake;
    logic                  stop_nmi;
    logic                  idle_nmi;

    // Pins are asynchronous; only the second stage is read
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            uv_s1_q  <= 1'b0;
            uv_s2_q  <= 1'b0;
        end else begin
            pin_s1_q <= lnk.ext_irq_pins;
            pin_s2_q <= pin_s1_q;
            uv_s1_q  <= lnk.undervolt_nmi;
            uv_s2_q  <= uv_s1_q;
        end
    end

    // ==========================================================
    // Wake qualification per mode
    // Deep stop: pins, I2C wake, undervolt NMI only
    assign stop_nmi  = uv_s2_q;
    assign stop_wake = |(pin_s2_q & lnk.ext_irq_en)
                     | (lnk.i2c_wake_irq & lnk.i2c_wake_en)
                     | stop_nmi;
    // Idle: every enabled source, tick and both NMIs allowed
    assign idle_nmi  = uv_s2_q | lnk.watchdog_nmi;
    assign idle_wake = |(pin_s2_q & lnk.ext_irq_en)
                     | |(lnk.periph_irq & lnk.periph_en)
                     | (lnk.i2c_wake_irq & lnk.i2c_wake_en)
                     | (lnk.system_tick_irq & lnk.system_tick_en)
                     | idle_nmi;

    // ==========================================================
    // Mode state machine; reset always lands in NORMAL
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= LPMC_NORMAL;
        end else begin
            case (state_q)
                LPMC_NORMAL: begin
                    if (lnk.wfi && lnk.mode_sel == LPMC_SEL_IDLE) begin
                        state_q <= LPMC_IDLE;
                    end else if (lnk.wfi &&
                                 lnk.mode_sel == LPMC_SEL_STOP) begin
                        state_q <= LPMC_STOP;
                    end
                end
                LPMC_IDLE: begin
                    if (idle_wake) begin
                        state_q <= LPMC_NORMAL;
                    end
                end
                LPMC_STOP: begin
                    if (stop_wake) begin
                        state_q <= LPMC_WARM;
                    end
                end
                LPMC_WARM: begin
                    if (wcnt_q == '0) begin
                        state_q <= LPMC_NORMAL;
                    end
                end
                default: state_q <= LPMC_NORMAL;
            endcase
        end
    end

    // Warm-up counter, loaded on deep-stop interrupt exit only
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wcnt_q <= '0;
        end else if (state_q == LPMC_STOP && stop_wake) begin
            wcnt_q <= lnk.warmup[WUP_W-1:0];
        end else if (state_q == LPMC_WARM && wcnt_q != '0) begin
            wcnt_q <= wcnt_q - 1'b1;
        end
    end

    // ==========================================================
    // Wake request to the core; held until back in NORMAL
    // Keeps the cause visible while warm-up runs, so handling
    // starts only once the system clock is valid
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wake_q <= 1'b0;
            nmi_q  <= 1'b0;
        end else if (state_q == LPMC_IDLE && idle_wake) begin
            wake_q <= 1'b1;
            nmi_q  <= idle_nmi;
        end else if (state_q == LPMC_STOP && stop_wake) begin
            wake_q <= 1'b1;
            nmi_q  <= stop_nmi;
        end else if (state_q == LPMC_NORMAL) begin
            wake_q <= 1'b0;
            nmi_q  <= 1'b0;
        end
    end

    // ==========================================================
    // Clock gating per mode
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            gate_q    <= LPMC_GATE_ALL;
            core_q    <= 1'b1;
            i2c_q     <= 1'b1;
            usb_q     <= 1'b1;
            wdog_ok_q <= 1'b1;
        end else begin
            case (state_q)
                LPMC_IDLE: begin
                    gate_q    <= LPMC_GATE_ALL;
                    core_q    <= 1'b0;
                    i2c_q     <= 1'b1;
                    usb_q     <= 1'b1;
                    wdog_ok_q <= 1'b0;
                end
                LPMC_STOP, LPMC_WARM: begin
                    gate_q    <= '0;
                    core_q    <= 1'b0;
                    i2c_q     <= 1'b1;
                    usb_q     <= 1'b1;
                    wdog_ok_q <= 1'b0;
                end
                default: begin
                    gate_q    <= LPMC_GATE_ALL;
                    core_q    <= 1'b1;
                    i2c_q     <= 1'b1;
                    usb_q     <= 1'b1;
                    wdog_ok_q <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Oscillator and clock source control
    // External source is only ever reachable from NORMAL by software
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            clk_src_q <= LPMC_CLK_IOSC;
            osc_q     <= 1'b1;
            clk_ok_q  <= 1'b1;
        end else begin
            case (state_q)
                LPMC_STOP: begin
                    clk_src_q <= LPMC_CLK_IOSC;
                    osc_q     <= stop_wake;
                    clk_ok_q  <= 1'b0;
                end
                LPMC_WARM: begin
                    clk_src_q <= LPMC_CLK_IOSC;
                    osc_q     <= 1'b1;
                    clk_ok_q  <= (wcnt_q == '0);
                end
                LPMC_NORMAL: begin
                    clk_src_q <= lnk.ext_clk_sel && ext_arm_q;
                    osc_q     <= 1'b1;
                    clk_ok_q  <= 1'b1;
                end
                default: begin
                    clk_src_q <= clk_src_q;
                    osc_q     <= 1'b1;
                    clk_ok_q  <= 1'b1;
                end
            endcase
        end
    end

    // Software must reselect the external source after every reset
    // or deep-stop exit; a request level left standing is not enough
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ext_arm_q <= 1'b0;
        end else if (state_q == LPMC_STOP || state_q == LPMC_WARM) begin
            ext_arm_q <= 1'b0;
        end else if (!lnk.ext_clk_sel) begin
            ext_arm_q <= 1'b1;
        end
    end

    // ==========================================================
    // Outputs straight from flip-flops, except undervolt_run which is tied high
    assign lnk.core_run      = core_q;
    assign lnk.wake_req      = wake_q;
    assign lnk.wake_nmi      = nmi_q;
    assign lnk.gate_en       = gate_q;
    assign lnk.i2c_wake_run  = i2c_q;
    assign lnk.usb_wake_run  = usb_q;
    assign lnk.undervolt_run = 1'b1;                // Detector never gated
    assign lnk.wdog_clear_ok = wdog_ok_q;
    assign lnk.clk_src       = clk_src_q;
    assign lnk.osc_int_on    = osc_q;
    assign lnk.sys_clk_ok    = clk_ok_q;
endmodule

// ---- hdl/lpmc_core.sv ----
// Core-side end: registers the WFI request, drives mode select and wake sources straight onto the link
`timescale 1ns/1ps
module lpmc_core (
    input  wire logic                            ref_clk,
    input  wire logic                            nrst,
    input  wire logic                            sleep_req,
    input  wire logic [1:0]                      sleep_mode,
    input  wire logic [11:0]                     warmup_cnt,
    input  wire logic                            want_ext_osc,
    input  wire logic [lpmc_pkg::LPMC_EXT_N-1:0] pins,
    input  wire logic [lpmc_pkg::LPMC_EXT_N-1:0] pins_en,
    input  wire logic [lpmc_pkg::LPMC_PER_N-1:0] irqs,
    input  wire logic [lpmc_pkg::LPMC_PER_N-1:0] irqs_en,
    input  wire logic                            i2c_wake,
    input  wire logic                            i2c_wake_ena,
    input  wire logic                            tick,
    input  wire logic                            tick_ena,
    input  wire logic                            wdog_nmi,
    input  wire logic                            uv_nmi,
    output logic                                 woke,
    output logic                                 woke_by_nmi,
    output logic                                 core_clk_on,
    lpmc_if.core                                 lnk
);
    import lpmc_pkg::*;

    // ==========================================================
    // Request side: WFI is a pulse, only legal selects pass
    logic wfi_q;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wfi_q <= 1'b0;
        end else begin
            wfi_q <= sleep_req && (sleep_mode == LPMC_SEL_IDLE ||
                                   sleep_mode == LPMC_SEL_STOP);
        end
    end

    // Sources pass through; software owns masking and enables
    assign lnk.wfi             = wfi_q;
    assign lnk.mode_sel        = sleep_mode;
    assign lnk.warmup          = warmup_cnt;
    assign lnk.ext_clk_sel     = want_ext_osc;
    assign lnk.ext_irq_pins    = pins;
    assign lnk.ext_irq_en      = pins_en;
    assign lnk.periph_irq      = irqs;
    assign lnk.periph_en       = irqs_en;
    assign lnk.i2c_wake_irq    = i2c_wake;
    assign lnk.i2c_wake_en     = i2c_wake_ena;
    assign lnk.system_tick_irq = tick;
    assign lnk.system_tick_en  = tick_ena;
    assign lnk.watchdog_nmi    = wdog_nmi;
    assign lnk.undervolt_nmi   = uv_nmi;

    // ==========================================================
    // Status back to the user, registered
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            woke        <= 1'b0;
            woke_by_nmi <= 1'b0;
            core_clk_on <= 1'b1;
        end else begin
            woke        <= lnk.wake_req && lnk.sys_clk_ok;
            woke_by_nmi <= lnk.wake_nmi;
            core_clk_on <= lnk.core_run;
        end
    end
endmodule

// ---- testbench/lpmc_sva.sv ----
// Checker: concurrent assertions on the low-power controller link
`timescale 1ns/1ps
module lpmc_sva (
    input wire logic                            ref_clk,
    input wire logic                            nrst,
    input wire logic                            wfi,
    input wire logic [1:0]                      mode_sel,
    input wire logic [11:0]                     warmup,
    input wire logic [lpmc_pkg::LPMC_EXT_N-1:0] ext_irq_pins,
    input wire logic [lpmc_pkg::LPMC_EXT_N-1:0] ext_irq_en,
    input wire logic [lpmc_pkg::LPMC_PER_N-1:0] periph_irq,
    input wire logic [lpmc_pkg::LPMC_PER_N-1:0] periph_en,
    input wire logic                            i2c_wake_irq,
    input wire logic                            i2c_wake_en,
    input wire logic                            system_tick_irq,
    input wire logic                            system_tick_en,
    input wire logic                            watchdog_nmi,
    input wire logic                            undervolt_nmi,
    input wire logic                            core_run,
    input wire logic                            wake_req,
    input wire logic                            wake_nmi,
    input wire logic [lpmc_pkg::LPMC_GATE_N-1:0] gate_en,
    input wire logic                            i2c_wake_run,
    input wire logic                            usb_wake_run,
    input wire logic                            wdog_clear_ok,
    input wire logic                            clk_src,
    input wire logic                            osc_int_on,
    input wire logic                            sys_clk_ok
);
    import lpmc_pkg::*;
    // ==========================================================
    // Helper logic
    logic [12:0] warm_cnt_q;
    logic        idle_w;
    logic        stop_w;
    logic        stop_src_w;
    logic        idle_src_w;
    // Asleep views; wake_req excluded so warm-up is never mistaken for them
    assign idle_w     = !core_run && osc_int_on && !wake_req;
    assign stop_w     = !osc_int_on && !wake_req;
    assign stop_src_w = (|(ext_irq_pins & ext_irq_en)) || undervolt_nmi
                        || (i2c_wake_irq && i2c_wake_en);
    assign idle_src_w = stop_src_w || (|(periph_irq & periph_en))
                        || (system_tick_irq && system_tick_en) || watchdog_nmi;
    // Warm-up length, counted while the clock is withheld after a wake
    always_ff @(posedge ref_clk) begin
        if (!nrst || !wake_req || sys_clk_ok) begin
            warm_cnt_q <= 13'h0;
        end else begin
            warm_cnt_q <= warm_cnt_q + 13'h1;
        end
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    stop_gating_a : assert property (
        wfi && core_run && mode_sel == LPMC_SEL_STOP |-> ##[1:3] (!core_run
        && gate_en == '0 && i2c_wake_run && usb_wake_run))
        else $error("Deep stop gating wrong");
    idle_gating_a : assert property (
        wfi && core_run && mode_sel == LPMC_SEL_IDLE |-> ##[1:3] (!core_run
        && gate_en == LPMC_GATE_ALL && !wdog_clear_ok && sys_clk_ok))
        else $error("Idle gating wrong");
    int_osc_a : assert property (
        !sys_clk_ok |-> clk_src == LPMC_CLK_IOSC)
        else $error("Clock source not internal");
    stop_refuse_a : assert property (
        (stop_w && !stop_src_w) [*4] |=> !wake_req)
        else $error("Deep stop woken by refused source");
    stop_wake_a : assert property (
        stop_w && stop_src_w |-> ##[1:4] wake_req)
        else $error("Deep stop not woken");
    idle_refuse_a : assert property (
        (idle_w && !idle_src_w) [*4] |=> !wake_req)
        else $error("Idle woken without enabled source");
    idle_wake_a : assert property (
        idle_w && idle_src_w |-> ##[1:4] wake_req)
        else $error("Idle not woken");
    wdt_nmi_a : assert property (
        idle_w && watchdog_nmi |-> ##[1:4] (wake_req && wake_nmi))
        else $error("Watchdog wake not flagged as nmi");
    warm_len_a : assert property ($rose(sys_clk_ok) && wake_req |->
        warm_cnt_q >= {1'b0, warmup} && warm_cnt_q <= {1'b0, warmup} + 13'h3)
        else $error("Warm-up length wrong");
    wake_hold_a : assert property (wake_req && !sys_clk_ok |=> wake_req)
        else $error("Wake request dropped early");
    exit_restore_a : assert property ($fell(wake_req) |-> core_run
        && gate_en == LPMC_GATE_ALL && wdog_clear_ok)
        else $error("Normal clocks not restored");
    // Main scenarios reached
    stop_entry_c : cover property (wfi && mode_sel == LPMC_SEL_STOP);
    warm_done_c : cover property ($rose(sys_clk_ok) && wake_req);
    nmi_wake_c : cover property (wake_req && wake_nmi);
endmodule

// ---- testbench/lpmc_tb_top.sv ----
// Testbench: both ends of the low-power controller joined and exercised
`timescale 1ns/1ps
module lpmc_tb_top;
    import lpmc_pkg::*;
    localparam logic [11:0] WUP = 12'h010;
    logic        ref_clk, nrst, sleep_req, want_ext_osc;
    logic        i2c_wake, i2c_wake_ena, tick, tick_ena, wdog_nmi, uv_nmi;
    logic        woke, woke_by_nmi, core_clk_on;
    logic [1:0]  sleep_mode;
    logic [11:0] warmup_cnt;
    logic [5:0]  pins, pins_en;
    logic [23:0] irqs, irqs_en;
    int          num_errors, compares, cyc;
    // ==========================================================
    // Both ends and the checker on one link
    lpmc_if lnk ();
    lpmc_ctrl #(.WUP_W(LPMC_WUP_W)) i_lpmc_ctrl (.ref_clk(ref_clk),
        .nrst(nrst), .lnk(lnk));
    lpmc_core i_lpmc_core (.ref_clk(ref_clk), .nrst(nrst),
        .sleep_req(sleep_req), .sleep_mode(sleep_mode),
        .warmup_cnt(warmup_cnt), .want_ext_osc(want_ext_osc), .pins(pins),
        .pins_en(pins_en), .irqs(irqs), .irqs_en(irqs_en),
        .i2c_wake(i2c_wake), .i2c_wake_ena(i2c_wake_ena), .tick(tick),
        .tick_ena(tick_ena), .wdog_nmi(wdog_nmi), .uv_nmi(uv_nmi), .woke(woke),
        .woke_by_nmi(woke_by_nmi), .core_clk_on(core_clk_on), .lnk(lnk));
    lpmc_sva i_lpmc_sva (.ref_clk(ref_clk), .nrst(nrst), .wfi(lnk.wfi),
        .mode_sel(lnk.mode_sel), .warmup(lnk.warmup),
        .ext_irq_pins(lnk.ext_irq_pins), .ext_irq_en(lnk.ext_irq_en),
        .periph_irq(lnk.periph_irq), .periph_en(lnk.periph_en),
        .i2c_wake_irq(lnk.i2c_wake_irq), .i2c_wake_en(lnk.i2c_wake_en),
        .system_tick_irq(lnk.system_tick_irq),
        .system_tick_en(lnk.system_tick_en), .watchdog_nmi(lnk.watchdog_nmi),
        .undervolt_nmi(lnk.undervolt_nmi), .core_run(lnk.core_run),
        .wake_req(lnk.wake_req), .wake_nmi(lnk.wake_nmi),
        .gate_en(lnk.gate_en), .i2c_wake_run(lnk.i2c_wake_run),
        .usb_wake_run(lnk.usb_wake_run), .wdog_clear_ok(lnk.wdog_clear_ok),
        .clk_src(lnk.clk_src), .osc_int_on(lnk.osc_int_on),
        .sys_clk_ok(lnk.sys_clk_ok));
    // ==========================================================
    // Tasks
    task automatic complete_run();
        $display("Errors %0d Compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait: 0 woke, 1 core clock back, 2 core clock stopped
    task automatic wait_hi(input int which, input int lim);
        logic v;
        cyc = 0;
        v = 1'b0;
        while (v !== 1'b1) begin
            @(negedge ref_clk);
            cyc++;
            v = (which == 0) ? woke
              : (which == 1) ? core_clk_on : ~core_clk_on;
            if (cyc > lim && v !== 1'b1) begin
                num_errors++;
                $display("ERROR t=%0t wait %0d got=%h exp=%h", $time, which,
                         v, 1'b1);
                complete_run();
            end
        end
    endtask
    task automatic sleep(input logic [1:0] m);
        sleep_mode = m;
        sleep_req = 1'b1;
        @(negedge ref_clk);
        sleep_req = 1'b0;
        wait_hi(2, 10);
    endtask
    // Sources held until the wake is seen, only then released
    task automatic finish_wake();
        {tick_ena, wdog_nmi, uv_nmi, i2c_wake} = 4'h0;
        {pins, irqs, irqs_en, tick} = '0;
        wait_hi(1, 20);
        repeat (4) @(negedge ref_clk);
    endtask
    // ==========================================================
    // Clock and sequence
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        {num_errors, compares, cyc} = '0;
        {nrst, sleep_req, want_ext_osc, tick, tick_ena, wdog_nmi} = '0;
        {uv_nmi, i2c_wake, pins, irqs, irqs_en} = '0;
        sleep_mode = LPMC_SEL_IDLE;
        warmup_cnt = WUP;
        pins_en = 6'h3f;
        i2c_wake_ena = 1'b1;
        repeat (20) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        chk({core_clk_on, woke, lnk.clk_src}, 3'h4);
        chk(lnk.gate_en, LPMC_GATE_ALL);
        want_ext_osc = 1'b1;
        // Reserved select is dropped by the core, no mode is entered
        sleep_mode = 2'h2;
        sleep_req = 1'b1;
        @(negedge ref_clk);
        sleep_req = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk(core_clk_on, 1'b1);
        chk(lnk.clk_src, LPMC_CLK_EOSC);
        // Idle: masked source first, then tick, watchdog nmi, peripheral
        for (int j = 0; j < 3; j++) begin
            tick = 1'b1;
            irqs = 24'h00_0080;
            sleep(LPMC_SEL_IDLE);
            repeat (10) @(negedge ref_clk);
            chk(woke, 1'b0);
            chk(lnk.gate_en, LPMC_GATE_ALL);
            chk(lnk.wdog_clear_ok, 1'b0);
            tick_ena = (j == 0);
            wdog_nmi = (j == 1);
            irqs_en = (j == 2) ? 24'h00_0080 : 24'h00_0000;
            wait_hi(0, 20);
            chk(woke_by_nmi, j == 1);
            finish_wake();
        end
        // Deep stop: refused sources pending, then pin, i2c, undervolt
        for (int k = 0; k < 3; k++) begin
            sleep(LPMC_SEL_STOP);
            {irqs, irqs_en} = 48'hffff_ffff_ffff;
            {tick, tick_ena, wdog_nmi} = 3'h7;
            repeat (2) @(negedge ref_clk);
            chk(lnk.gate_en, 14'h0000);
            chk({lnk.i2c_wake_run, lnk.usb_wake_run}, 2'h3);
            chk(lnk.undervolt_run, 1'b1);
            chk(lnk.clk_src, LPMC_CLK_IOSC);
            repeat (30) @(negedge ref_clk);
            chk(woke, 1'b0);
            pins = (k == 0) ? 6'h08 : 6'h00;
            i2c_wake = (k == 1);
            uv_nmi = (k == 2);
            wait_hi(0, 100);
            chk(cyc >= WUP + 1 && cyc <= WUP + 10, 1'b1);
            chk(woke_by_nmi, k == 2);
            chk(lnk.clk_src, LPMC_CLK_IOSC);
            finish_wake();
        end
        // Reset pin releases deep stop, no warm-up afterwards
        sleep(LPMC_SEL_STOP);
        nrst = 1'b0;
        repeat (20) @(negedge ref_clk);
        chk(lnk.clk_src, LPMC_CLK_IOSC);
        nrst = 1'b1;
        @(negedge ref_clk);
        chk({core_clk_on, woke, lnk.sys_clk_ok}, 3'h5);
        chk(lnk.gate_en, LPMC_GATE_ALL);
        repeat (4) @(negedge ref_clk);
        chk(lnk.clk_src, LPMC_CLK_IOSC);
        complete_run();
    end
endmodule
